// ---- verilog/scwdm_pkg.sv ----
// constants for the scan cycle watchdog monitor
package scwdm_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
    // 10 ms = 100 ticks, 1 ms = 10 ticks of 0.1 ms
    localparam logic [31:0] TICKS_PER_10MS = 32'h0000_0064;
    localparam logic [31:0] TICKS_PER_1MS = 32'h0000_000A;
    localparam logic [31:0] DEFAULT_LIMIT_TICKS = 32'h0000_2710;  // 1 s
    localparam logic [31:0] SERVICE_LIMIT_TICKS = 32'h0000_4E20;  // 2.0 s
    localparam logic [14:0] LIMIT_CODE_MAX = 15'h0FA0;
    localparam logic [15:0] MIN_CYCLE_MAX = 16'h7D00;  // 32000 ms
    localparam int WATCH_EN_BIT = 15;
    localparam logic [8:0] OFS_MIN_CYCLE = 9'h0D0;
    localparam logic [8:0] OFS_WATCH = 9'h0D1;
    localparam logic [8:0] OFS_LONGEST_LO = 9'h106;
    localparam logic [8:0] OFS_LONGEST_HI = 9'h107;
    localparam logic [8:0] OFS_LATEST_LO = 9'h108;
    localparam logic [8:0] OFS_LATEST_HI = 9'h109;
    localparam logic [8:0] OFS_AVERAGE_LO = 9'h10A;
    localparam logic [8:0] OFS_AVERAGE_HI = 9'h10B;
    localparam logic [8:0] OFS_SERVICE = 9'h10C;
    localparam logic [8:0] OFS_FLAGS = 9'h10D;
    localparam logic [15:0] MIN_CYCLE_RESET = 16'h0000;
    localparam logic [15:0] WATCH_RESET = 16'h0000;
    localparam int AVG_DEPTH = 8;
    localparam int AVG_SHIFT = 3;
    typedef enum logic [1:0] {SCWDM_IDLE, SCWDM_RUN, SCWDM_PAD, SCWDM_HALT} scwdm_state_t;
endpackage

// ---- verilog/scwdm_timer.sv ----
// 0.1 ms tick counter with elapsed-time accumulator
`timescale 1ns/1ps
module scwdm_timer (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clear_in,
    input wire logic run_in,
    output logic [31:0] ticks_out
);
    logic [11:0] pre_q;

    // prescaler restarts with the count so every cycle begins on a whole tick
    always_ff @(posedge clk_in) begin
        if (srst_in || clear_in) begin
            pre_q <= 12'h000;
            ticks_out <= 32'h0000_0000;
        end else if (run_in) begin
            if (pre_q == scwdm_pkg::TICK_LAST) begin
                pre_q <= 12'h000;
                // saturate rather than wrap
                if (ticks_out != 32'hFFFF_FFFF) begin
                    ticks_out <= ticks_out + 32'h0000_0001;
                end
            end else begin
                pre_q <= pre_q + 12'h001;
            end
        end
    end
endmodule

// ---- verilog/scwdm_top.sv ----
// cycle watchdog, cycle time monitor and register port
`timescale 1ns/1ps
// Overview of operation
// - bit 15 selects programmed limit, else 1 s
// - limit field counts 10 ms, 001 to FA0
// - cycle over limit sets flag and halts
// - parallel mode supervises program execution only
// - servicing over 2 s sets flag, halts
// - longest cycle time kept, 0.1 ms units
// - latest cycle time stored every cycle
// - average of last eight cycles readable
// - parallel mode records each servicing cycle time
// - short cycles padded to minimum cycle time, except in parallel mode
module scwdm_top (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic parallel_mode_in,
    input wire logic exec_start_in,
    input wire logic exec_done_in,
    input wire logic serv_start_in,
    input wire logic serv_done_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [8:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic cycle_done_out,
    output logic halt_out,
    output logic cycle_overrun_flag_out,
    output logic servicing_overrun_flag_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    scwdm_pkg::scwdm_state_t state_q;
    logic [15:0] min_cycle_q;
    logic [15:0] watch_q;
    logic [31:0] longest_q;
    logic [31:0] latest_q;
    logic [15:0] service_word_q;
    logic [31:0] hist_q [scwdm_pkg::AVG_DEPTH];
    logic [34:0] hist_sum_q;
    logic [31:0] cyc_ticks;
    logic [31:0] srv_ticks;
    logic cyc_clear;
    logic cyc_run;
    logic srv_busy_q;
    logic [31:0] limit_ticks;
    logic [31:0] min_ticks;
    logic end_of_cycle;
    logic over_cycle;
    logic over_serv;

    // ------------------------------------------------------------
    // limits
    // ------------------------------------------------------------
    always_comb begin
        if (watch_q[scwdm_pkg::WATCH_EN_BIT]) begin
            limit_ticks = 32'(watch_q[14:0]) * scwdm_pkg::TICKS_PER_10MS;
        end else begin
            limit_ticks = scwdm_pkg::DEFAULT_LIMIT_TICKS;
        end
        min_ticks = 32'(min_cycle_q) * scwdm_pkg::TICKS_PER_1MS;
    end

    // ------------------------------------------------------------
    // cycle timers
    // ------------------------------------------------------------
    // in parallel mode the cycle is program execution only; otherwise the
    // measured cycle runs from one execution start to the next, servicing included
    assign cyc_clear = exec_start_in && (state_q != scwdm_pkg::SCWDM_HALT);
    assign cyc_run = (state_q == scwdm_pkg::SCWDM_RUN) || (state_q == scwdm_pkg::SCWDM_PAD);
    assign end_of_cycle = (state_q == scwdm_pkg::SCWDM_RUN) &&
        (parallel_mode_in ? exec_done_in : exec_start_in);
    assign over_cycle = cyc_run && (state_q == scwdm_pkg::SCWDM_RUN) &&
        (cyc_ticks > limit_ticks);
    assign over_serv = srv_busy_q && (srv_ticks > scwdm_pkg::SERVICE_LIMIT_TICKS);

    scwdm_timer u_cycle_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .clear_in(cyc_clear),
        .run_in(cyc_run),
        .ticks_out(cyc_ticks)
    );

    scwdm_timer u_serv_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .clear_in(serv_start_in),
        .run_in(srv_busy_q),
        .ticks_out(srv_ticks)
    );

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            srv_busy_q <= 1'b0;
        end else if (serv_start_in) begin
            srv_busy_q <= 1'b1;
        end else if (serv_done_in) begin
            srv_busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= scwdm_pkg::SCWDM_IDLE;
        end else begin
            unique case (state_q)
                scwdm_pkg::SCWDM_IDLE: begin
                    if (exec_start_in) begin
                        state_q <= scwdm_pkg::SCWDM_RUN;
                    end
                end
                scwdm_pkg::SCWDM_RUN: begin
                    if (over_cycle || over_serv) begin
                        state_q <= scwdm_pkg::SCWDM_HALT;
                    end else if (parallel_mode_in && exec_done_in) begin
                        state_q <= scwdm_pkg::SCWDM_IDLE;
                    end else if (!parallel_mode_in && exec_done_in && cyc_ticks < min_ticks) begin
                        state_q <= scwdm_pkg::SCWDM_PAD;
                    end
                end
                scwdm_pkg::SCWDM_PAD: begin
                    if (over_serv) begin
                        state_q <= scwdm_pkg::SCWDM_HALT;
                    end else if (cyc_ticks >= min_ticks) begin
                        // back to run so the padded length is what the next start records
                        state_q <= scwdm_pkg::SCWDM_RUN;
                    end
                end
                scwdm_pkg::SCWDM_HALT: begin
                    state_q <= scwdm_pkg::SCWDM_HALT;
                end
            endcase
            if (over_serv) begin
                state_q <= scwdm_pkg::SCWDM_HALT;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs and flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cycle_overrun_flag_out <= 1'b0;
            servicing_overrun_flag_out <= 1'b0;
            halt_out <= 1'b0;
            cycle_done_out <= 1'b0;
        end else begin
            if (over_cycle) begin
                cycle_overrun_flag_out <= 1'b1;
            end
            if (over_serv) begin
                servicing_overrun_flag_out <= 1'b1;
            end
            halt_out <= halt_out || over_cycle || over_serv;
            // pad ends in run; caller may start the next cycle once this pulses
            cycle_done_out <= ((state_q == scwdm_pkg::SCWDM_PAD) && (cyc_ticks >= min_ticks))
                || ((state_q == scwdm_pkg::SCWDM_RUN) && exec_done_in && !over_cycle
                    && (parallel_mode_in || cyc_ticks >= min_ticks));
        end
    end

    // ------------------------------------------------------------
    // cycle statistics
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            latest_q <= 32'h0000_0000;
            longest_q <= 32'h0000_0000;
            hist_sum_q <= 35'h0_0000_0000;
            for (int i = 0; i < scwdm_pkg::AVG_DEPTH; i++) begin
                hist_q[i] <= 32'h0000_0000;
            end
        end else if (end_of_cycle && !over_cycle) begin
            latest_q <= cyc_ticks;
            if (cyc_ticks > longest_q) begin
                longest_q <= cyc_ticks;
            end
            // running sum avoids an eight-way adder on the read path
            hist_sum_q <= hist_sum_q + 35'(cyc_ticks) -
                35'(hist_q[scwdm_pkg::AVG_DEPTH - 1]);
            hist_q[0] <= cyc_ticks;
            for (int i = 1; i < scwdm_pkg::AVG_DEPTH; i++) begin
                hist_q[i] <= hist_q[i - 1];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            service_word_q <= 16'h0000;
        end else if (parallel_mode_in && srv_busy_q && serv_done_in) begin
            // saturates at the word width
            service_word_q <= (srv_ticks[31:16] != 16'h0000) ? 16'hFFFF : srv_ticks[15:0];
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            min_cycle_q <= scwdm_pkg::MIN_CYCLE_RESET;
            watch_q <= scwdm_pkg::WATCH_RESET;
        end else if (reg_wr_in) begin
            if (reg_addr_in == scwdm_pkg::OFS_MIN_CYCLE) begin
                // out-of-range minimum clamps to the top of the legal span
                min_cycle_q <= (reg_wdata_in > scwdm_pkg::MIN_CYCLE_MAX) ?
                    scwdm_pkg::MIN_CYCLE_MAX : reg_wdata_in;
            end
            if (reg_addr_in == scwdm_pkg::OFS_WATCH) begin
                // illegal code zero or above FA0 keeps the old setting
                if (!reg_wdata_in[scwdm_pkg::WATCH_EN_BIT] || ((reg_wdata_in[14:0] != 15'h0000)
                    && (reg_wdata_in[14:0] <= scwdm_pkg::LIMIT_CODE_MAX))) begin
                    watch_q <= reg_wdata_in;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                scwdm_pkg::OFS_MIN_CYCLE: reg_rdata_out <= min_cycle_q;
                scwdm_pkg::OFS_WATCH: reg_rdata_out <= watch_q;
                scwdm_pkg::OFS_LONGEST_LO: reg_rdata_out <= longest_q[15:0];
                scwdm_pkg::OFS_LONGEST_HI: reg_rdata_out <= longest_q[31:16];
                scwdm_pkg::OFS_LATEST_LO: reg_rdata_out <= latest_q[15:0];
                scwdm_pkg::OFS_LATEST_HI: reg_rdata_out <= latest_q[31:16];
                scwdm_pkg::OFS_AVERAGE_LO: reg_rdata_out <= hist_sum_q[18:3];
                scwdm_pkg::OFS_AVERAGE_HI: reg_rdata_out <= hist_sum_q[34:19];
                scwdm_pkg::OFS_SERVICE: reg_rdata_out <= service_word_q;
                scwdm_pkg::OFS_FLAGS: reg_rdata_out <= {13'h0000, halt_out,
                    servicing_overrun_flag_out, cycle_overrun_flag_out};
                default: reg_rdata_out <= 16'h0000;
            endcase
        end
    end
endmodule

// ---- verif/scwdm_asserts.sv ----
// concurrent checks on the watchdog monitor ports
`timescale 1ns/1ps
module scwdm_asserts (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic reg_rd_in,
    input wire logic [8:0] reg_addr_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic cycle_done_out,
    input wire logic halt_out,
    input wire logic cycle_overrun_flag_out,
    input wire logic servicing_overrun_flag_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // ------------------------------
    // register reads
    // ------------------------------
    sequence flag_read_s;
        reg_rd_in && reg_addr_in == 9'h10D;
    endsequence
    sequence hole_read_s;
        reg_rd_in && !(reg_addr_in inside {9'h0D0, 9'h0D1, [9'h106:9'h10D]});
    endsequence
    flags_read_a: assert property (flag_read_s |=> reg_rdata_out == {13'h0000,
        $past(halt_out), $past(servicing_overrun_flag_out), $past(cycle_overrun_flag_out)})
        else $error("flag word wrong");
    hole_read_a: assert property (hole_read_s |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved");
    // ------------------------------
    // flags, halt, cycle end
    // ------------------------------
    cyc_sticky_a: assert property (cycle_overrun_flag_out |=> cycle_overrun_flag_out)
        else $error("cycle flag dropped");
    serv_sticky_a: assert property (servicing_overrun_flag_out |=> servicing_overrun_flag_out)
        else $error("servicing flag dropped");
    halt_sticky_a: assert property (halt_out |=> halt_out)
        else $error("halt dropped");
    halt_cause_a: assert property (halt_out |-> cycle_overrun_flag_out || servicing_overrun_flag_out)
        else $error("halt without cause");
    cyc_halt_a: assert property ($rose(cycle_overrun_flag_out) |-> ##[0:1] halt_out)
        else $error("overrun did not halt");
    serv_halt_a: assert property ($rose(servicing_overrun_flag_out) |-> ##[0:1] halt_out)
        else $error("servicing overrun did not halt");
    done_pulse_a: assert property (cycle_done_out |=> !cycle_done_out)
        else $error("cycle end longer than one clock");
    reset_clear_a: assert property (disable iff (1'b0) $fell(srst_in) |-> !halt_out
        && !cycle_done_out && !cycle_overrun_flag_out && !servicing_overrun_flag_out)
        else $error("outputs not cleared by reset");
endmodule

// ---- verif/tb_scwdm_top.sv ----
// self-checking bench for the watchdog monitor
`timescale 1ns/1ps
module tb_scwdm_top;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic par = 1'b0;
    logic [3:0] ev = 4'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic done, halt, cyc_flag, serv_flag;
    logic [31:0] seed = 32'h1C72;
    logic [15:0] wt [4] = '{16'h8FA0, 16'h8FA1, 16'h8000, 16'h0123};
    logic [15:0] wx [4] = '{16'h8FA0, 16'h8FA0, 16'h8FA0, 16'h0123};
    int errors = 0;
    int comparisons = 0;
    int n;
    always #20 clk_in = ~clk_in;
    scwdm_top scwdm_top_i (.clk_in(clk_in), .srst_in(srst_in), .parallel_mode_in(par),
        .exec_start_in(ev[0]), .exec_done_in(ev[1]), .serv_start_in(ev[2]),
        .serv_done_in(ev[3]), .reg_wr_in(wr_en), .reg_rd_in(rd_en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .cycle_done_out(done), .halt_out(halt),
        .cycle_overrun_flag_out(cyc_flag), .servicing_overrun_flag_out(serv_flag));
    // ------------------------------
    // helpers
    // ------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] clamp(input logic [15:0] w);
        return (w > 16'h7D00) ? 16'h7D00 : w;
    endfunction
    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_in);
        ev <= 4'(1 << k);
        @(posedge clk_in);
        ev <= 4'h0;
    endtask
    // interval of k ticks plus half a tick, so tick phase cannot flip the count
    task automatic span(input int k, input int s);
        pulse(s);
        repeat (k * 2500 + 1250) @(posedge clk_in);
        pulse(s + 1);
        repeat (2) @(posedge clk_in);
    endtask
    task automatic wait_done(output int c);
        c = 0;
        while (done !== 1'b1) begin
            @(posedge clk_in);
            ev <= 4'h0;
            #1;
            c++;
            if (c > 30000) begin
                errors++;
                wrap_up();
            end
        end
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(9'h0D0, 16'h0000);
        rd(9'h0D1, 16'h0000);
        wr(9'h106, 16'hFFFF);
        rd(9'h106, 16'h0000);
        rd(9'h0D5, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(9'h0D1, wt[i]);
            rd(9'h0D1, wx[i]);
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(9'h0D0, seed[15:0]);
            rd(9'h0D0, clamp(seed[15:0]));
        end
        wr(9'h0D0, 16'h0000);
        par <= 1'b1;
        span(11, 0);
        span(5, 0);
        rd(9'h108, 16'h0005);
        rd(9'h109, 16'h0000);
        rd(9'h106, 16'h000B);
        rd(9'h107, 16'h0000);
        rd(9'h10A, 16'h0002);
        span(2, 2);
        rd(9'h10C, 16'h0002);
        par <= 1'b0;
        pulse(0);
        repeat (20) @(posedge clk_in);
        ev <= 4'h2;
        wait_done(n);
        chk_in(n, 1, 1);
        wr(9'h0D0, 16'h0001);
        pulse(0);
        @(posedge clk_in);
        ev <= 4'h2;
        wait_done(n);
        chk_in(n, 22500, 25010);
        // the padded cycle is recorded at the next start, padding included
        pulse(0);
        rd(9'h108, 16'h000A);
        rd(9'h10A, 16'h0003);
        rd(9'h10D, 16'h0000);
        chk({13'h0000, halt, serv_flag, cyc_flag}, 16'h0000);
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(9'h0D0, 16'h0000);
        wrap_up();
    end
endmodule
bind scwdm_top scwdm_asserts scwdm_asserts_i (.clk_in(clk_in), .srst_in(srst_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out),
    .cycle_done_out(cycle_done_out), .halt_out(halt_out),
    .cycle_overrun_flag_out(cycle_overrun_flag_out),
    .servicing_overrun_flag_out(servicing_overrun_flag_out));
